// ===== eprom_host_pkg.sv
// package: constants and carrier types for the eprom host controller
package eprom_host_pkg;

    localparam int ADDR_WIDTH = 11;
    localparam int DATA_WIDTH = 8;
    localparam int CLK_PERIOD_NS = 100;
    // timing figures in their own units
    localparam int ACCESS_NS = 450;           // address_access_delay
    localparam int OE_DELAY_NS = 120;         // output_enable_delay
    localparam int FLOAT_NS = 100;
    localparam int SETUP_US = 2;
    localparam int HOLD_US = 2;
    localparam int PULSE_NOM_MS = 50;
    localparam int PULSE_MAX_MS = 55;
    // derived cycle counts: least times round up, longest round down
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (SETUP_US * 1000 + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_US * 1000 + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int PULSE_NOM_CYC = PULSE_NOM_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PULSE_MAX_CYC = PULSE_MAX_MS * 1000000 / CLK_PERIOD_NS;
    localparam int COUNT_WIDTH = 20;

    typedef struct packed {
        logic                  chipEnableN;
        logic                  outputEnableN;
        logic                  programSupplyHigh;
        logic                  chipEnableProgramPulse;
        logic [ADDR_WIDTH-1:0] address;
        logic [DATA_WIDTH-1:0] dataOut;
        logic                  dataOe;
    } pins_type;

endpackage : eprom_host_pkg

// ===== eprom_host.sv
// eprom_host: read and program controller driving a 2k x 8 uv eprom
module eprom_host
    import eprom_host_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_NOM_CYC
)(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // user side
    input  wire logic                  reqValid,
    input  wire logic                  reqWrite,
    input  wire logic [ADDR_WIDTH-1:0] reqAddress,
    input  wire logic [DATA_WIDTH-1:0] reqData,
    output      logic                  reqReady,
    output      logic                  rspValid,
    output      logic [DATA_WIDTH-1:0] rspData,
    output      logic                  rspVerifyFail,
    // device pins
    output      logic                  chipEnableN,
    output      logic                  outputEnableN,
    output      logic                  programSupplyHigh,
    output      logic                  chipEnableProgramPulse,
    output      logic [ADDR_WIDTH-1:0] address,
    output      logic [DATA_WIDTH-1:0] dataOut,
    output      logic                  dataOe,
    input  wire logic [DATA_WIDTH-1:0] dataIn
);

    initial
    begin
        if (PULSE_CYCLES < 1 || PULSE_CYCLES > PULSE_MAX_CYC
            || PULSE_CYCLES >= (1 << COUNT_WIDTH))
            $error("PULSE_CYCLES out of range");
    end

    typedef enum logic [3:0] {
        IDLE, RD_ACCESS, RD_FLOAT, PG_SUPPLY, PG_SETUP, PG_PULSE,
        PG_HOLD, PG_VERIFY, PG_RELEASE, PG_DOWN
    } phase_type;

    typedef struct packed {
        phase_type             phase;
        logic [COUNT_WIDTH-1:0] count;
        pins_type              pins;
        logic [DATA_WIDTH-1:0] wrData;
        logic                  rspValid;
        logic [DATA_WIDTH-1:0] rspData;
        logic                  rspVerifyFail;
        logic [DATA_WIDTH-1:0] sync1;
        logic [DATA_WIDTH-1:0] sync2;
        logic [DATA_WIDTH-1:0] sync3;
    } state_type;

    state_type state;
    state_type next_state;

    function automatic logic [COUNT_WIDTH-1:0] cyc(input int n);
        cyc = COUNT_WIDTH'(n);
    endfunction : cyc

    // standby pin state: chip off, outputs off, normal supply, no pulse
    function automatic pins_type idlePins(input logic [ADDR_WIDTH-1:0] a);
        idlePins = '{chipEnableN: 1'b1, outputEnableN: 1'b1,
                     programSupplyHigh: 1'b0, chipEnableProgramPulse: 1'b0,
                     address: a, dataOut: '0, dataOe: 1'b0};
    endfunction : idlePins

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_state = state;
        next_state.rspValid = 1'b0;
        // data pins cross in from the device: three flops, agree on 2 and 3
        next_state.sync1 = dataIn;
        next_state.sync2 = state.sync1;
        next_state.sync3 = state.sync2;
        if (state.count != '0)
            next_state.count = state.count - 1'b1;
        unique case (state.phase)
            IDLE:
            begin
                next_state.pins = idlePins(state.pins.address);
                if (reqValid)
                begin
                    next_state.pins.address = reqAddress;
                    if (reqWrite)
                    begin
                        // supply switches only with output enable high and
                        // chip enable low, never with both high
                        next_state.pins.chipEnableN = 1'b0;
                        next_state.wrData = reqData;
                        next_state.count = cyc(SETUP_CYC);
                        next_state.phase = PG_SUPPLY;
                    end
                    else
                    begin
                        // both enables fall together: no late-oe penalty
                        next_state.pins.chipEnableN = 1'b0;
                        next_state.pins.outputEnableN = 1'b0;
                        next_state.count = cyc(ACCESS_CYC + 2);
                        next_state.phase = RD_ACCESS;
                    end
                end
            end
            RD_ACCESS:
                // wait access time plus synchroniser depth, address held
                if (state.count == '0 && state.sync2 == state.sync3)
                begin
                    next_state.rspValid = 1'b1;
                    next_state.rspData = state.sync3;
                    next_state.rspVerifyFail = 1'b0;
                    next_state.pins.chipEnableN = 1'b1;
                    next_state.pins.outputEnableN = 1'b1;
                    next_state.count = cyc(FLOAT_CYC);
                    next_state.phase = RD_FLOAT;
                end
            RD_FLOAT:
                if (state.count == '0)
                    next_state.phase = IDLE;
            PG_SUPPLY:
            begin
                next_state.pins.programSupplyHigh = 1'b1;
                next_state.pins.outputEnableN = 1'b1;
                next_state.pins.chipEnableN = 1'b1;
                next_state.pins.dataOut = state.wrData;
                next_state.pins.dataOe = 1'b1;
                next_state.phase = PG_SETUP;
            end
            PG_SETUP:
                // address and data settle before the pulse
                if (state.count == '0)
                begin
                    next_state.pins.chipEnableProgramPulse = 1'b1;
                    next_state.count = cyc(PULSE_CYCLES - 1);
                    next_state.phase = PG_PULSE;
                end
            PG_PULSE:
                // bounded: never a static level, never past the maximum
                if (state.count == '0)
                begin
                    next_state.pins.chipEnableProgramPulse = 1'b0;
                    next_state.count = cyc(HOLD_CYC);
                    next_state.phase = PG_HOLD;
                end
            PG_HOLD:
                if (state.count == '0)
                begin
                    // verify at high supply: chip and output enable low
                    next_state.pins.dataOe = 1'b0;
                    next_state.pins.chipEnableN = 1'b0;
                    next_state.pins.outputEnableN = 1'b0;
                    next_state.count = cyc(ACCESS_CYC + 2);
                    next_state.phase = PG_VERIFY;
                end
            PG_VERIFY:
                if (state.count == '0 && state.sync2 == state.sync3)
                begin
                    next_state.rspValid = 1'b1;
                    next_state.rspData = state.sync3;
                    // mismatch also flags ones that pulsing cannot restore
                    next_state.rspVerifyFail =
                        state.sync3 != state.wrData;
                    next_state.pins.outputEnableN = 1'b1;
                    next_state.count = cyc(FLOAT_CYC);
                    next_state.phase = PG_RELEASE;
                end
            PG_RELEASE:
                // drop the supply with chip low and output high
                if (state.count == '0)
                begin
                    next_state.pins.programSupplyHigh = 1'b0;
                    next_state.count = cyc(HOLD_CYC);
                    next_state.phase = PG_DOWN;
                end
            PG_DOWN:
                if (state.count == '0)
                begin
                    next_state.pins.chipEnableN = 1'b1;
                    next_state.phase = IDLE;
                end
            default:
                next_state.phase = IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state <= '{phase: IDLE, count: '0, pins: idlePins('0),
                       wrData: '0, rspValid: 1'b0, rspData: '1,
                       rspVerifyFail: 1'b0, sync1: '0, sync2: '0, sync3: '0};
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign reqReady = state.phase == IDLE;
    assign rspValid = state.rspValid;
    assign rspData = state.rspData;
    assign rspVerifyFail = state.rspVerifyFail;
    assign chipEnableN = state.pins.chipEnableN;
    assign outputEnableN = state.pins.outputEnableN;
    assign programSupplyHigh = state.pins.programSupplyHigh;
    assign chipEnableProgramPulse = state.pins.chipEnableProgramPulse;
    assign address = state.pins.address;
    assign dataOut = state.pins.dataOut;
    assign dataOe = state.pins.dataOe;

endmodule : eprom_host

// ===== eprom_host_chk.sv
// checker: pin sequencing assertions for the eprom host controller
module eprom_host_chk
    import eprom_host_pkg::*;
#(
    parameter int PULSE_CYCLES = 10
)(
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire logic                  rspValid,
    input wire logic                  chipEnableN,
    input wire logic                  outputEnableN,
    input wire logic                  programSupplyHigh,
    input wire logic                  chipEnableProgramPulse,
    input wire logic [ADDR_WIDTH-1:0] address,
    input wire logic [DATA_WIDTH-1:0] dataOut,
    input wire logic                  dataOe
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic [COUNT_WIDTH-1:0] pulseCnt, readCnt;
    logic                   cePin;
    // level the device sees on its shared enable and program input
    assign cePin = programSupplyHigh ? chipEnableProgramPulse : chipEnableN;
    always_ff @(posedge clk_sys)
    begin
        pulseCnt <= chipEnableProgramPulse ? pulseCnt + 1'b1 : '0;
        readCnt <= (!chipEnableN && !outputEnableN) ? readCnt + 1'b1 : '0;
    end
    pulse_mode_a: assert property (chipEnableProgramPulse |->
        programSupplyHigh && outputEnableN) else $error("pulse out of mode");
    pulse_data_a: assert property (chipEnableProgramPulse |-> dataOe &&
        $stable(address) && $stable(dataOut)) else $error("pulse data moved");
    pulse_max_a: assert property (pulseCnt <= PULSE_CYCLES)
        else $error("program pulse too long");
    pulse_len_a: assert property ($fell(chipEnableProgramPulse) |->
        pulseCnt == PULSE_CYCLES) else $error("program pulse length wrong");
    supply_switch_a: assert property ($changed(programSupplyHigh) |->
        !($past(outputEnableN) && $past(cePin)) && !(outputEnableN && cePin))
        else $error("supply switched with both enables high");
    read_wait_a: assert property (rspValid |-> readCnt >= ACCESS_CYC)
        else $error("data sampled before access delay");
    drive_clash_a: assert property (dataOe |->
        outputEnableN && programSupplyHigh) else $error("data drive clash");
    oe_after_ce_a: assert property (!outputEnableN |-> !chipEnableN)
        else $error("output enable without chip enable");
    cover property ($fell(chipEnableProgramPulse));
    cover property (rspValid && programSupplyHigh);
    cover property (rspValid && !programSupplyHigh);
endmodule : eprom_host_chk
////////////////////////////////////////////////////////////////////////////
bind eprom_host eprom_host_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .rspValid(rspValid), .dataOe(dataOe),
    .chipEnableN(chipEnableN), .outputEnableN(outputEnableN),
    .programSupplyHigh(programSupplyHigh), .address(address),
    .chipEnableProgramPulse(chipEnableProgramPulse), .dataOut(dataOut));

// ===== eprom_model.sv
// partner model: 2k x 8 uv eprom as seen from its pins
module eprom_model
    import eprom_host_pkg::*;
#(
    parameter int ACC_NS = 400
)(
    input  wire logic                  chipEnableN,
    input  wire logic                  outputEnableN,
    input  wire logic                  programSupplyHigh,
    input  wire logic                  chipEnableProgramPulse,
    input  wire logic [ADDR_WIDTH-1:0] address,
    input  wire logic [DATA_WIDTH-1:0] dataOut,
    input  wire logic                  dataOe,
    output wire logic [DATA_WIDTH-1:0] dataIn
);
    logic [DATA_WIDTH-1:0] mem [2**ADDR_WIDTH];
    logic [DATA_WIDTH-1:0] last = 8'h00;
    logic                  drive;
    initial
        foreach (mem[i]) mem[i] = 8'hff;
    // write lands as the pulse ends; zeros never turn back to ones
    always @(negedge chipEnableProgramPulse)
        if (programSupplyHigh && outputEnableN && dataOe)
            mem[address] = mem[address] & dataOut;
    assign drive = !chipEnableN && !outputEnableN;
    always @(drive or address)
        if (drive)
            last = mem[address];
    // released pins show the inverse of the last byte, not a held value
    assign #(ACC_NS) dataIn = drive ? mem[address] : ~last;
endmodule : eprom_model

// ===== eprom_host_test.sv
// testbench: reads, programs and verifies through the eprom host controller
module eprom_host_test
    import eprom_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  clk_sys, rst, reqValid, reqWrite, reqReady;
    logic                  rspValid, rspVerifyFail, chipEnableN, dataOe;
    logic                  outputEnableN, programSupplyHigh, pulse;
    logic [ADDR_WIDTH-1:0] reqAddress, address;
    logic [DATA_WIDTH-1:0] reqData, rspData, dataOut, dataIn;
    logic [DATA_WIDTH-1:0] shadow [2**ADDR_WIDTH];
    logic [DATA_WIDTH:0]   expQ [$];
    logic [31:0]           rng = 32'h00006ff3;
    int                    error_cnt = 0, compares = 0, cycles = 0;
    eprom_host #(.PULSE_CYCLES(10)) u_eprom_host (.clk_sys(clk_sys),
        .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddress(reqAddress), .reqData(reqData), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .dataIn(dataIn),
        .rspVerifyFail(rspVerifyFail), .chipEnableN(chipEnableN),
        .outputEnableN(outputEnableN), .programSupplyHigh(programSupplyHigh),
        .chipEnableProgramPulse(pulse), .address(address),
        .dataOut(dataOut), .dataOe(dataOe));
    eprom_model u_eprom_model (.chipEnableN(chipEnableN),
        .outputEnableN(outputEnableN), .programSupplyHigh(programSupplyHigh),
        .chipEnableProgramPulse(pulse), .address(address),
        .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    // note the expectation as the request goes out; valid stays up
    task automatic op(input logic wr, input logic [10:0] a,
                      input logic [7:0] d);
        @(negedge clk_sys);
        reqValid = 1'b1;
        reqWrite = wr;
        reqAddress = a;
        reqData = d;
        if (wr)
            shadow[a] = shadow[a] & d;
        expQ.push_back({wr && shadow[a] != d, shadow[a]});
        do @(posedge clk_sys); while (reqReady !== 1'b1);
    endtask : op
    always @(posedge clk_sys)
    begin
        cycles++;
        if (rspValid === 1'b1)
            check({rspVerifyFail, rspData}, expQ.pop_front());
        if (cycles == 20000)
        begin
            error_cnt++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        foreach (shadow[i]) shadow[i] = 8'hff;
        rst = 1'b1;
        {reqValid, reqWrite, reqAddress, reqData} = '0;
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        op(1'b0, 11'h000, 8'h00);
        op(1'b0, 11'h7ff, 8'h00);
        op(1'b1, 11'h7ff, 8'h5a);
        op(1'b1, 11'h7ff, 8'ha5);
        op(1'b0, 11'h7ff, 8'h00);
        repeat (6)
        begin
            rng = xs(rng);
            op(1'b1, rng[10:0], rng[23:16]);
            op(1'b0, rng[10:0], rng[31:24]);
        end
        @(negedge clk_sys);
        reqValid = 1'b0;
        while (expQ.size() != 0)
            @(negedge clk_sys);
        repeat (30) @(negedge clk_sys);
        summarize();
    end
endmodule : eprom_host_test
